// ===== logic/dcc_pkg.sv
// package of constants and types for the dma completion control block
package dcc_pkg;
   // ********************************************
   // register map
   // ********************************************
   localparam logic [7:0] DCC_ADDR_CTRL = 8'h00;
   localparam logic [7:0] DCC_ADDR_SRC = 8'h04;
   localparam logic [7:0] DCC_ADDR_DST = 8'h08;
   localparam logic [7:0] DCC_ADDR_COUNT = 8'h0c;
   localparam logic [7:0] DCC_ADDR_STATUS = 8'h10;
   // ********************************************
   // control fields
   // ********************************************
   localparam int DCC_RUN_LSB = 0;
   localparam int DCC_STOP_BIT = 2;
   localparam int DCC_IRQEN_BIT = 3;
   localparam logic [1:0] DCC_RUN_HALT = 2'h0;
   localparam logic [31:0] DCC_CTRL_RESET = 32'h0;
   localparam logic [23:0] DCC_ADDR_RESET = 24'h0;
   localparam logic [23:0] DCC_COUNT_RESET = 24'h0;
   localparam int DCC_AW = 24;
   localparam int DCC_DW = 32;
   typedef enum {DCC_IDLE, DCC_RD, DCC_WR} dcc_state_t;
endpackage : dcc_pkg

// ===== logic/dcc_word_if.sv
// handshake carrier for one data word between the engine and its buffer
`timescale 1ns/100ps
interface dcc_word_if #(parameter int W = 32);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface : dcc_word_if

// ===== logic/dcc_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module dcc_skid #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic flush,
   // ports
   dcc_word_if.dst in_p,
   dcc_word_if.src out_p
);
   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic [1:0] cnt;
      logic rd;
      logic wr;
   } dcc_skid_t;
   dcc_skid_t s_reg, s_next;
   logic push, pop;
   always_comb begin
      push = in_p.valid && (s_reg.cnt != 2'h2);
      pop = out_p.ready && (s_reg.cnt != 2'h0);
      s_next = s_reg;
      if (push) begin
         s_next.mem[s_reg.wr] = in_p.data;
         s_next.wr = ~s_reg.wr;
      end
      if (pop) begin
         s_next.rd = ~s_reg.rd;
      end
      s_next.cnt = s_reg.cnt + {1'b0, push} - {1'b0, pop};
      if (flush) begin
         s_next.cnt = 2'h0;
         s_next.rd = 1'b0;
         s_next.wr = 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
   assign in_p.ready = (s_reg.cnt != 2'h2);
   assign out_p.valid = (s_reg.cnt != 2'h0);
   assign out_p.data = s_reg.mem[s_reg.rd];
endmodule : dcc_skid

// ===== logic/dcc_arb.sv
// memory grant logic: on a conflict the dma waits behind every cpu unit
`timescale 1ns/100ps
module dcc_arb (
   // cpu unit requests and busy
   input wire logic [3:0] cpu_req,
   input wire logic cpu_busy,
   // dma side
   input wire logic dma_req,
   input wire logic dma_conflict,
   output logic dma_grant
);
   // ********************************************
   // lowest priority grant
   // ********************************************
   // a conflict exists only when both sides address the same resource
   always_comb begin
      dma_grant = dma_req && !(dma_conflict && ((|cpu_req) || cpu_busy)); // [R12] [R13]
   end
endmodule : dcc_arb

// ===== logic/dcc_top.sv
// dma completion, run control and memory sequencing of a single channel
// Behaviour
// [R1] at zero count after the last transfer a completion event is raised only when count_zero_irq_enable is 1.
// [R2] the cpu takes the event only when its own cpu_dma_irq_enable (bit 10 of cpu_irq_enable_reg) is set.
// [R3] with stop_at_zero at 1 transfers cease once the count becomes zero.
// [R4] with stop_at_zero at 0 transfers carry on past a zero count.
// [R5] software should clear stop_at_zero whenever the completion event is disabled.
// [R6] a terminated channel reports, stays halted and accepts a fresh start.
// [R7] clearing the run field, even by writing all zeros to control, halts the channel.
// [R8] after reset the channel is halted and moves no data.
// [R9] software configures with the run field at 00 before starting.
// [R10] software starts by writing a nonzero run field.
// [R11] every control register is a mapped location on the peripheral port.
// [R12] the dma ranks below execute, read, decode and fetch and waits while they finish.
// [R13] the dma has its own address and data buses, conflicting only on a shared resource.
// [R14] the completion event is one clock cycle long per zero-count occurrence.
`timescale 1ns/100ps
module dcc_top
   import dcc_pkg::*;
#(
   parameter int AW = dcc_pkg::DCC_AW,
   parameter int DW = dcc_pkg::DCC_DW
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // cpu arbitration
   input wire logic [3:0] cpu_req,
   input wire logic cpu_busy,
   input wire logic mem_conflict,
   // dma memory bus
   output logic [AW-1:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [DW-1:0] mem_wdata,
   input wire logic [DW-1:0] mem_rdata,
   input wire logic mem_ack,
   // completion event
   output logic done_irq
);
   import dcc_pkg::*;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [AW-1:0] src;
      logic [AW-1:0] dst;
      logic [23:0] count;
      dcc_state_t state;
      logic [31:0] rdata;
      logic irq;
      logic rd_pend;
      logic wr_pend;
      logic [DW-1:0] wdata;
      logic stopped;
   } dcc_top_t;

   dcc_top_t s_reg, s_next;
   dcc_word_if #(.W(DW)) buf_in ();
   dcc_word_if #(.W(DW)) buf_out ();
   logic grant, running, want, wr_go;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // ********************************************
   // buffer and arbiter
   // ********************************************
   dcc_skid #(.W(DW)) u_buf (
      .clk(clk),
      .resetn(resetn),
      .flush(!running),
      .in_p(buf_in),
      .out_p(buf_out)
   );

   dcc_arb u_arb (
      .cpu_req(cpu_req),
      .cpu_busy(cpu_busy),
      .dma_req(want),
      .dma_conflict(mem_conflict),
      .dma_grant(grant)
   );

   assign running = (s_reg.ctrl[DCC_RUN_LSB +: 2] != DCC_RUN_HALT); // [R7] [R8]
   assign buf_in.valid = s_reg.rd_pend && mem_ack;
   assign buf_in.data = mem_rdata;
   assign buf_out.ready = (s_reg.state == DCC_WR) && s_reg.wr_pend && mem_ack;
   // a write is offered only once the registered copy of the word is current
   assign wr_go = grant && (s_reg.wdata == buf_out.data);

   always_comb begin
      want = 1'b0;
      case (s_reg.state)
         DCC_RD: want = buf_in.ready;
         DCC_WR: want = buf_out.valid;
         default: want = 1'b0;
      endcase
   end

   // ********************************************
   // next state
   // ********************************************
   always_comb begin
      s_next = s_reg;
      s_next.irq = 1'b0; // [R14]
      s_next.rdata = 32'h0;
      if (reg_read) begin
         if (hit(reg_addr, DCC_ADDR_CTRL)) begin
            s_next.rdata = s_reg.ctrl;
         end else if (hit(reg_addr, DCC_ADDR_SRC)) begin
            s_next.rdata = {{(32-AW){1'b0}}, s_reg.src};
         end else if (hit(reg_addr, DCC_ADDR_DST)) begin
            s_next.rdata = {{(32-AW){1'b0}}, s_reg.dst};
         end else if (hit(reg_addr, DCC_ADDR_COUNT)) begin
            s_next.rdata = {8'h0, s_reg.count};
         end else if (hit(reg_addr, DCC_ADDR_STATUS)) begin
            s_next.rdata = {29'h0, s_reg.stopped, (s_reg.state == DCC_WR), (s_reg.state == DCC_RD)};
         end
      end
      // a control write restarts a terminated channel; a termination in the same cycle wins
      if (reg_write && hit(reg_addr, DCC_ADDR_CTRL)) begin
         s_next.stopped = 1'b0; // [R6]
      end
      // sequencing; a grant moves one word
      case (s_reg.state)
         DCC_IDLE: begin
            if (running && !s_reg.stopped) begin
               s_next.state = DCC_RD;
            end
         end
         DCC_RD: begin
            if (grant && !s_reg.rd_pend) begin
               s_next.rd_pend = 1'b1;
            end
            if (s_reg.rd_pend && mem_ack) begin
               s_next.rd_pend = 1'b0;
               s_next.src = s_reg.src + {{(AW-1){1'b0}}, 1'b1};
               s_next.state = DCC_WR;
            end
         end
         DCC_WR: begin
            s_next.wdata = buf_out.data;
            // once started the write holds until acknowledged, whatever the cpu does
            if (wr_go && !s_reg.wr_pend) begin
               s_next.wr_pend = 1'b1;
            end
            if (buf_out.ready) begin
               s_next.wr_pend = 1'b0;
               s_next.dst = s_reg.dst + {{(AW-1){1'b0}}, 1'b1};
               s_next.count = s_reg.count - 24'h1;
               s_next.state = DCC_RD; // [R4]
               if (s_reg.count == 24'h1) begin
                  s_next.irq = s_reg.ctrl[DCC_IRQEN_BIT]; // [R1]
                  if (s_reg.ctrl[DCC_STOP_BIT]) begin
                     s_next.stopped = 1'b1; // [R3] [R6]
                     s_next.state = DCC_IDLE;
                  end
                  // without stop_at_zero the count wraps and transfers carry on
               end
            end
         end
         default: s_next.state = DCC_IDLE;
      endcase
      if (!running) begin
         s_next.state = DCC_IDLE;
         s_next.rd_pend = 1'b0;
         s_next.wr_pend = 1'b0;
      end
      // register writes
      if (reg_write) begin
         if (hit(reg_addr, DCC_ADDR_CTRL)) begin
            s_next.ctrl = reg_wdata; // [R7]
         end else if (hit(reg_addr, DCC_ADDR_SRC)) begin
            s_next.src = reg_wdata[AW-1:0];
         end else if (hit(reg_addr, DCC_ADDR_DST)) begin
            s_next.dst = reg_wdata[AW-1:0];
         end else if (hit(reg_addr, DCC_ADDR_COUNT)) begin
            s_next.count = reg_wdata[23:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_reg.ctrl <= DCC_CTRL_RESET; // [R8]
         s_reg.src <= DCC_ADDR_RESET;
         s_reg.dst <= DCC_ADDR_RESET;
         s_reg.count <= DCC_COUNT_RESET;
         s_reg.state <= DCC_IDLE;
         s_reg.rdata <= 32'h0;
         s_reg.irq <= 1'b0;
         s_reg.rd_pend <= 1'b0;
         s_reg.wr_pend <= 1'b0;
         s_reg.wdata <= '0;
         s_reg.stopped <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ********************************************
   // outputs
   // ********************************************
   // own bus: the cpu buses never carry these
   assign mem_rd = (s_reg.state == DCC_RD) && (s_reg.rd_pend || grant); // [R13]
   assign mem_wr = (s_reg.state == DCC_WR) && (s_reg.wr_pend || wr_go); // [R12]
   assign mem_addr = (s_reg.state == DCC_WR) ? s_reg.dst : s_reg.src;
   assign mem_wdata = s_reg.wdata;
   assign reg_rdata = s_reg.rdata; // [R11]
   assign done_irq = s_reg.irq; // [R14]
endmodule : dcc_top

// ===== testbench/dcc_props.sv
// assertion checker for the dma completion control top
`timescale 1ns/100ps
module dcc_props
   import dcc_pkg::*;
#(parameter int AW = 24, parameter int DW = 32) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   // cpu arbitration
   input wire logic [3:0] cpu_req,
   input wire logic cpu_busy,
   input wire logic mem_conflict,
   // memory bus
   input wire logic [AW-1:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [DW-1:0] mem_wdata,
   input wire logic [DW-1:0] mem_rdata,
   input wire logic mem_ack,
   // completion event
   input wire logic done_irq
);
   logic [3:0] ctl_reg;
   logic ctl_wr;
   assign ctl_wr = reg_write && reg_addr == DCC_ADDR_CTRL;
   // shadow of the control fields, so checks need no peek inside
   always_ff @(posedge clk) begin
      if (!resetn) ctl_reg <= 4'h0;
      else if (ctl_wr) ctl_reg <= reg_wdata[3:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_irq_one_cycle: assert property (done_irq |=> !done_irq) else $error("irq long");
   a_irq_enable: assert property (done_irq |-> ctl_reg[3]) else $error("irq masked");
   a_stop_halts: assert property (done_irq && ctl_reg[2] && !reg_write |=> !mem_rd && !mem_wr)
      else $error("no stop");
   a_run_on: assert property (done_irq && !ctl_reg[2] && !reg_write |-> ##[1:40] mem_rd)
      else $error("stalled");
   a_zero_halts: assert property (ctl_wr && reg_wdata[1:0] == DCC_RUN_HALT
      |-> ##[1:20] (!mem_rd && !mem_wr) [*8]) else $error("no halt");
   a_cpu_first: assert property (mem_conflict && (|cpu_req || cpu_busy)
      && !$past(mem_rd) && !$past(mem_wr) |-> !mem_rd && !mem_wr) else $error("dma first");
   a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !mem_rd && !mem_wr && !done_irq)
      else $error("busy");
   a_ctrl_readback: assert property (reg_read && reg_addr == DCC_ADDR_CTRL |=> reg_rdata[3:0] == ctl_reg)
      else $error("ctrl read");
endmodule : dcc_props
bind dcc_top dcc_props #(.AW(AW), .DW(DW)) u_props (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .cpu_req(cpu_req),
   .cpu_busy(cpu_busy), .mem_conflict(mem_conflict), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
   .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .done_irq(done_irq));

// ===== testbench/dcc_far_model.sv
// memory and cpu interrupt model at the far side of the dma
`timescale 1ns/100ps
module dcc_far_model #(parameter int AW = 24, parameter int DW = 32) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // memory bus
   input wire logic [AW-1:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   output logic [DW-1:0] mem_rdata,
   output logic mem_ack,
   // cpu side
   input wire logic slow,
   input wire logic [31:0] cpu_irq_enable_reg,
   input wire logic done_irq,
   output int taken
);
   logic [1:0] wait_reg;
   logic fire;
   assign fire = (mem_rd || mem_wr) && !mem_ack && wait_reg == 2'h0;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         mem_ack <= 1'b0;
         wait_reg <= 2'h0;
         taken <= 0;
         mem_rdata <= '0;
      end else begin
         mem_ack <= fire;
         // read data only valid with the ack, toggling otherwise
         mem_rdata <= (mem_rd && fire) ? DW'({8'ha5, mem_addr} ^ 32'h0f0f0f0f) : ~mem_rdata;
         if (mem_ack) wait_reg <= slow ? 2'($urandom) : 2'h0;
         else if ((mem_rd || mem_wr) && wait_reg != 2'h0) wait_reg <= wait_reg - 2'h1;
         if (done_irq && cpu_irq_enable_reg[10]) taken <= taken + 1;
      end
   end
endmodule : dcc_far_model

// ===== testbench/dcc_top_tb_top.sv
// self-checking bench for the dma completion control top
`timescale 1ns/100ps
module dcc_top_tb_top;
   import dcc_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, slow = 1'b0;
   logic [7:0] reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0, ie = 32'h0, reg_rdata, mem_wdata, mem_rdata, d;
   logic [3:0] cpu_req = 4'h0;
   logic cpu_busy = 1'b0, mem_conflict = 1'b0, mem_rd, mem_wr, mem_ack, done_irq;
   logic [23:0] mem_addr, src, dst;
   int taken, t0, n, irq0, bad_count = 0, checks = 0, wr_n = 0, wr_base = 0, irq_n = 0;
   initial forever #10 clk = ~clk;
   dcc_top DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .cpu_req(cpu_req), .cpu_busy(cpu_busy), .mem_conflict(mem_conflict),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .done_irq(done_irq));
   dcc_far_model far (.clk(clk), .resetn(resetn), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .slow(slow), .cpu_irq_enable_reg(ie), .done_irq(done_irq), .taken(taken));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // word that the memory model returns for a source address
   function automatic logic [31:0] exp_word(input logic [23:0] a);
      exp_word = {8'ha5, a} ^ 32'h0f0f0f0f;
   endfunction : exp_word
   task automatic close_out;
      $display("errors %0d checks %0d", bad_count, checks);
      if (bad_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic run_job(input logic irq, input logic stop, input int cnt);
      src = 24'($urandom);
      dst = 24'($urandom);
      wr_base = wr_n;
      wr(DCC_ADDR_CTRL, {28'h0, irq, stop, 2'h0});
      wr(DCC_ADDR_SRC, {8'h0, src});
      wr(DCC_ADDR_DST, {8'h0, dst});
      wr(DCC_ADDR_COUNT, 32'(cnt));
      wr(DCC_ADDR_CTRL, {28'h0, irq, stop, 2'(1 + $urandom % 3)});
   endtask : run_job
   // cpu units contend at random; conflict kept rare so the dma still progresses
   always @(posedge clk) begin
      cpu_req <= 4'($urandom);
      cpu_busy <= 1'($urandom);
      mem_conflict <= ($urandom % 4) == 0;
   end
   // every completed write and every completion pulse is counted here
   always @(posedge clk) begin
      if (resetn && done_irq) begin
         irq_n <= irq_n + 1;
      end
      if (resetn && mem_ack && mem_wr) begin
         chk({8'h0, mem_addr}, {8'h0, dst + 24'(wr_n - wr_base)});
         chk(mem_wdata, exp_word(src + 24'(wr_n - wr_base)));
         wr_n <= wr_n + 1;
      end
   end
   initial begin
      #400000;
      bad_count++;
      close_out();
   end
   initial begin
      void'($urandom(32'h6424ca9f));
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (10) @(posedge clk);
      chk(wr_n, 0);
      rd(DCC_ADDR_CTRL);
      chk(d, DCC_CTRL_RESET);
      rd(8'h14);
      chk(d, 32'h0);
      // stop_at_zero only together with the completion event, as software should
      for (int i = 0; i < 4; i++) begin
         n = (i == 0) ? 1 : 1 + $urandom % 4;
         slow <= i[1];
         ie <= i[0] ? 32'h400 : 32'h0;
         t0 = taken;
         irq0 = irq_n;
         run_job(1'b1, 1'b1, n);
         d = 32'h0;
         for (int k = 0; k < 100 && d[2] !== 1'b1; k++) rd(DCC_ADDR_STATUS);
         chk(d, 32'h4);
         rd(DCC_ADDR_SRC);
         chk(d, {8'h0, src + 24'(n)});
         chk(wr_n - wr_base, n);
         chk(irq_n - irq0, 1);
         chk(taken - t0, i[0]);
      end
      // free running past zero, with and without the completion event, then halted by software
      for (int j = 1; j >= 0; j--) begin
         irq0 = irq_n;
         run_job(j[0], 1'b0, 2);
         repeat (120) @(posedge clk);
         chk(wr_n - wr_base > 2, 1);
         chk(irq_n - irq0, j);
         wr(DCC_ADDR_CTRL, 32'h0);
         repeat (30) @(posedge clk);
         n = wr_n;
         repeat (30) @(posedge clk);
         chk(wr_n, n);
         rd(DCC_ADDR_STATUS);
         chk(d, 32'h0);
      end
      close_out();
   end
endmodule : dcc_top_tb_top
